// ---- mafa_frame_src.sv ----
// Purpose: Frame path model standing for the wired MAC and radio receive paths
// Assumes: One descriptor per call, driven by non-blocking assignment at a rising edge
// Notes:   Between frames the descriptor lines show the inverse of the last frame
`timescale 1ns/1ps
module mafa_frame_src (
    input  wire logic               clk_i,
    output logic                    frame_valid_o,
    output mafa_pkg::mafa_frame_type frame_o
);
    // Idle lines carry the inverted last value so stale data cannot pass for fresh
    initial begin
        frame_valid_o = 1'b0;
        frame_o       = '0;
    end

    // One-cycle descriptor, then the lines are scrambled again
    task automatic send(input logic p, input logic [47:0] d, input logic [47:0] s);
        @(posedge clk_i);
        frame_valid_o <= 1'b1;
        frame_o       <= {p, d, s};
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
        frame_o       <= ~{p, d, s};
    endtask
endmodule // mafa_frame_src

// ---- mafa_pkg.sv ----
// Purpose: Shared constants and carriers for the address filter and aging block
// Assumes: 20 MHz system clock, APB register access, one aligned word per register
// Notes:   Filter table words live at FILT_BASE + {port, entry, word}
package mafa_pkg;
    // Clock and aging timebase
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned TICK_S         = 1;
    localparam int unsigned TICK_CYCLES_DF = TICK_S * CLK_HZ;

    // Table sizes
    localparam int unsigned N_FILT = 32;
    localparam int unsigned N_LRN  = 16;

    // Register offsets
    localparam logic [11:0] CTRL_OFS  = 12'h000;
    localparam logic [11:0] LIFE_OFS  = 12'h004;
    localparam logic [11:0] LRN_OFS   = 12'h008;
    localparam int unsigned FT_SEL_BIT  = 10;
    localparam int unsigned FT_PORT_BIT = 9;
    localparam int unsigned FT_ENT_LSB  = 4;
    localparam int unsigned FT_WORD_LSB = 2;

    // Control fields and reset values
    localparam int unsigned CTRL_WIRED_BIT = 0;
    localparam int unsigned CTRL_RADIO_BIT = 1;
    localparam logic [1:0]  CTRL_RST       = 2'h0;

    // Entry lifetime in seconds
    localparam logic [5:0] LIFE_MIN = 6'h06;
    localparam logic [5:0] LIFE_MAX = 6'h28;
    localparam logic [5:0] LIFE_RST = 6'h14;

    // Filter word 3 fields
    localparam int unsigned W3_REJ_BIT = 16;
    localparam int unsigned W3_DIR_BIT = 17;

    typedef logic [3:0] mafa_lidx_type;
    typedef logic [4:0] mafa_fidx_type;

    // Frame addresses presented for a decision; port 0 wired, 1 radio
    typedef struct packed {
        logic        port;
        logic [47:0] dst;
        logic [47:0] src;
    } mafa_frame_type;

    typedef struct packed {
        logic        dir_dst;
        logic        reject;
        logic [47:0] mask;
        logic [47:0] addr;
    } mafa_filt_type;

    typedef struct packed {
        logic        vld;
        logic        port;
        logic [5:0]  age;
        logic [47:0] addr;
    } mafa_lrn_type;
endpackage

// ---- mafa_top.sv ----
// Purpose: Per-port address filter and learned source table with aging
// Assumes: Frames arrive as one-cycle descriptors; APB3 slave, zero wait states
// Notes:   Decision appears the cycle after the descriptor
`timescale 1ns/1ps
module mafa_top #(
    parameter int unsigned TICK_CYCLES = mafa_pkg::TICK_CYCLES_DF
) (
    input  wire logic                     REF_CLK_I,
    input  wire logic                     RSTN_I,
    input  wire logic                     PSEL_I,
    input  wire logic                     PENABLE_I,
    input  wire logic                     PWRITE_I,
    input  wire logic [11:0]              PADDR_I,
    input  wire logic [31:0]              PWDATA_I,
    output logic      [31:0]              PRDATA_O,
    output logic                          PREADY_O,
    output logic                          PSLVERR_O,
    input  wire logic                     FRAME_VALID_I,
    input  wire mafa_pkg::mafa_frame_type FRAME_I,
    output logic                          FWD_VALID_O,
    output logic                          FWD_PASS_O,
    output logic                          FWD_KNOWN_O,
    output logic                          FWD_PORT_O
);
    mafa_pkg::mafa_filt_type filt [2][mafa_pkg::N_FILT];
    mafa_pkg::mafa_lrn_type  lrn [mafa_pkg::N_LRN];
    logic [1:0]              ctrl;
    logic [5:0]              life;
    logic [31:0]             presc;
    logic                    tick;
    logic [31:0]             next_rdata;
    logic                    next_err;
    logic                    wr_go;
    logic                    ft_sel;
    logic                    ft_port;
    mafa_pkg::mafa_fidx_type ft_ent;
    logic [1:0]              ft_word;
    mafa_pkg::mafa_filt_type ft_rd;
    logic [31:0]             fhit;
    logic [31:0]             fused;
    logic [31:0]             frej;
    logic                    rej;
    logic                    src_found;
    mafa_pkg::mafa_lidx_type src_idx;
    logic                    dst_found;
    logic                    dst_port;
    logic                    free_ok;
    mafa_pkg::mafa_lidx_type free_idx;

    // Bus address split
    assign ft_sel  = PADDR_I[mafa_pkg::FT_SEL_BIT] && !PADDR_I[11] && (PADDR_I[1:0] == 2'h0);
    assign ft_port = PADDR_I[mafa_pkg::FT_PORT_BIT];
    assign ft_ent  = PADDR_I[mafa_pkg::FT_ENT_LSB +: 5];
    assign ft_word = PADDR_I[mafa_pkg::FT_WORD_LSB +: 2];
    assign ft_rd   = filt[ft_port][ft_ent];
    // Writes land only at the edge where the master sees pready
    assign wr_go   = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

    // Read mux and decode; unknown addresses answer with an error
    always_comb begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        if (ft_sel) begin
            case (ft_word)
                2'h0: next_rdata = ft_rd.addr[31:0];
                2'h1: next_rdata = {16'h0, ft_rd.addr[47:32]};
                2'h2: next_rdata = ft_rd.mask[31:0];
                2'h3: next_rdata = {14'h0, ft_rd.dir_dst, ft_rd.reject, ft_rd.mask[47:32]};
                default: next_rdata = 32'h0;
            endcase
        end else if (PADDR_I == mafa_pkg::CTRL_OFS) begin
            next_rdata = {30'h0, ctrl};
        end else if (PADDR_I == mafa_pkg::LIFE_OFS) begin
            next_rdata = {26'h0, life};
        end else if (PADDR_I == mafa_pkg::LRN_OFS) begin
            for (int i = 0; i < mafa_pkg::N_LRN; i++) begin
                next_rdata[i] = lrn[i].vld;
            end
        end else begin
            next_err = 1'b1;
        end
    end

    // One access cycle: ready raised for the edge after setup
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            if (PSEL_I && !PENABLE_I) begin
                PRDATA_O  <= PWRITE_I ? 32'h0 : next_rdata;
                PSLVERR_O <= next_err;
            end
        end
    end

    // Port filter enables
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            ctrl <= mafa_pkg::CTRL_RST;
        end else if (wr_go && PADDR_I == mafa_pkg::CTRL_OFS) begin
            ctrl <= PWDATA_I[1:0];
        end
    end

    // Lifetime is clamped so an out-of-range write cannot break aging
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            life <= mafa_pkg::LIFE_RST;
        end else if (wr_go && PADDR_I == mafa_pkg::LIFE_OFS) begin
            if (PWDATA_I < 32'(mafa_pkg::LIFE_MIN)) begin
                life <= mafa_pkg::LIFE_MIN;
            end else if (PWDATA_I > 32'(mafa_pkg::LIFE_MAX)) begin
                life <= mafa_pkg::LIFE_MAX;
            end else begin
                life <= PWDATA_I[5:0];
            end
        end
    end

    // Two filter tables, word-addressed by port and entry index
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            for (int p = 0; p < 2; p++) begin
                for (int e = 0; e < mafa_pkg::N_FILT; e++) begin
                    filt[p][e] <= '0;
                end
            end
        end else if (wr_go && ft_sel) begin
            case (ft_word)
                2'h0: filt[ft_port][ft_ent].addr[31:0]  <= PWDATA_I;
                2'h1: filt[ft_port][ft_ent].addr[47:32] <= PWDATA_I[15:0];
                2'h2: filt[ft_port][ft_ent].mask[31:0]  <= PWDATA_I;
                2'h3: begin
                    filt[ft_port][ft_ent].mask[47:32] <= PWDATA_I[15:0];
                    filt[ft_port][ft_ent].reject      <= PWDATA_I[mafa_pkg::W3_REJ_BIT];
                    filt[ft_port][ft_ent].dir_dst     <= PWDATA_I[mafa_pkg::W3_DIR_BIT];
                end
                default: ;
            endcase
        end
    end

    // Per-entry compare against the ingress port's own table
    for (genvar e = 0; e < mafa_pkg::N_FILT; e++) begin : g_filt
        mafa_pkg::mafa_filt_type t;
        logic [47:0]             cmp;
        assign t        = filt[FRAME_I.port][e];
        assign cmp      = t.dir_dst ? FRAME_I.dst : FRAME_I.src;
        assign fused[e] = |{t.addr, t.mask};
        // Mask bits gate the compare; ff is exact, 00 is don't-care
        assign fhit[e]  = fused[e] && (((cmp ^ t.addr) & t.mask) == 48'h0);
        assign frej[e]  = t.reject;
    end

    // Lowest index wins, so scan from the top down
    always_comb begin
        rej = 1'b0;
        for (int i = mafa_pkg::N_FILT - 1; i >= 0; i--) begin
            if (fhit[i]) begin
                rej = frej[i];
            end
        end
    end

    // Learned table search; lowest free slot is used for inserts
    always_comb begin
        src_found = 1'b0;
        src_idx   = '0;
        dst_found = 1'b0;
        dst_port  = 1'b0;
        free_ok   = 1'b0;
        free_idx  = '0;
        for (int i = mafa_pkg::N_LRN - 1; i >= 0; i--) begin
            if (lrn[i].vld && lrn[i].addr == FRAME_I.src) begin
                src_found = 1'b1;
                src_idx   = mafa_pkg::mafa_lidx_type'(i);
            end
            if (lrn[i].vld && lrn[i].addr == FRAME_I.dst) begin
                dst_found = 1'b1;
                dst_port  = lrn[i].port;
            end
            if (!lrn[i].vld) begin
                free_ok  = 1'b1;
                free_idx = mafa_pkg::mafa_lidx_type'(i);
            end
        end
    end

    // One-second prescaler for the aging timers
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            presc <= 32'h0;
            tick  <= 1'b0;
        end else begin
            tick  <= (presc == 32'(TICK_CYCLES - 1));
            presc <= (presc == 32'(TICK_CYCLES - 1)) ? 32'h0 : presc + 32'h1;
        end
    end

    // Learn, refresh and age; a refresh beats a same-cycle expiry
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < mafa_pkg::N_LRN; i++) begin
                lrn[i] <= '0;
            end
        end else begin
            for (int i = 0; i < mafa_pkg::N_LRN; i++) begin
                if (FRAME_VALID_I && src_found && src_idx == mafa_pkg::mafa_lidx_type'(i)) begin
                    lrn[i].age  <= life;
                    lrn[i].port <= FRAME_I.port;
                end else if (FRAME_VALID_I && !src_found && free_ok
                             && free_idx == mafa_pkg::mafa_lidx_type'(i)) begin
                    lrn[i].vld  <= 1'b1;
                    lrn[i].port <= FRAME_I.port;
                    lrn[i].age  <= life;
                    lrn[i].addr <= FRAME_I.src;
                end else if (tick && lrn[i].vld) begin
                    if (lrn[i].age <= 6'h01) begin
                        lrn[i].vld <= 1'b0;
                    end else begin
                        lrn[i].age <= lrn[i].age - 6'h01;
                    end
                end
            end
        end
    end

    // Decision register; unknown destinations cross to the other port
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            FWD_VALID_O <= 1'b0;
            FWD_PASS_O  <= 1'b0;
            FWD_KNOWN_O <= 1'b0;
            FWD_PORT_O  <= 1'b0;
        end else begin
            FWD_VALID_O <= FRAME_VALID_I;
            if (FRAME_VALID_I) begin
                FWD_PASS_O  <= !(ctrl[FRAME_I.port] && rej);
                FWD_KNOWN_O <= dst_found;
                FWD_PORT_O  <= dst_found ? dst_port : !FRAME_I.port;
            end
        end
    end

    property p_reject;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && ctrl[FRAME_I.port] && rej |=> FWD_VALID_O && !FWD_PASS_O;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected frame passed");

    property p_disabled;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && !ctrl[FRAME_I.port] |=> FWD_PASS_O;
    endproperty
    a_disabled: assert property (p_disabled) else $error("filter off yet dropped");

    property p_nomatch;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && (fhit == 32'h0) |=> FWD_VALID_O && FWD_PASS_O;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("unmatched frame dropped");

    // Entry 0 checked against raw storage, so a broken used-flag there cannot hide itself
    property p_unused;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && ({filt[FRAME_I.port][0].addr, filt[FRAME_I.port][0].mask} == 96'h0)
        |-> !fhit[0];
    endproperty
    a_unused: assert property (p_unused) else $error("unused entry matched");

    property p_known;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && dst_found |=> FWD_KNOWN_O && (FWD_PORT_O == $past(dst_port));
    endproperty
    a_known: assert property (p_known) else $error("known dest sent wrong way");

    property p_learn;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && !src_found && free_ok
        |=> lrn[$past(free_idx)].vld && lrn[$past(free_idx)].addr == $past(FRAME_I.src);
    endproperty
    a_learn: assert property (p_learn) else $error("source not learned");

    property p_refresh;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        FRAME_VALID_I && src_found |=> lrn[$past(src_idx)].age == $past(life);
    endproperty
    a_refresh: assert property (p_refresh) else $error("timer not restarted");

    // Every learned slot is watched; only a refresh of that same slot excuses it
    for (genvar i = 0; i < mafa_pkg::N_LRN; i++) begin : g_age
        property p_expire;
            @(posedge REF_CLK_I) disable iff (!RSTN_I)
            tick && lrn[i].vld && lrn[i].age == 6'h01
            && !(FRAME_VALID_I && src_found && src_idx == mafa_pkg::mafa_lidx_type'(i))
            |=> !lrn[i].vld;
        endproperty
        a_expire: assert property (p_expire) else $error("expired entry kept");
    end

    property p_life;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        ##1 (life >= mafa_pkg::LIFE_MIN) && (life <= mafa_pkg::LIFE_MAX);
    endproperty
    a_life: assert property (p_life) else $error("lifetime out of range");

    property p_tick;
        @(posedge REF_CLK_I) disable iff (!RSTN_I)
        tick |=> !tick ##0 (presc == 32'h1 || TICK_CYCLES == 1);
    endproperty
    a_tick: assert property (p_tick) else $error("second tick misplaced");
endmodule // mafa_top

// ---- mafa_top_tb.sv ----
// Purpose: Self-checking bench for the address filter and aging block
// Assumes: APB slave answers when it likes; one aging second shortened to 8 cycles
// Notes:   Frames come from the frame source model, at least one idle cycle apart
`timescale 1ns/1ps
module mafa_top_tb;
    localparam logic [47:0] SA   = 48'h021122334455;
    localparam logic [47:0] SB   = 48'h021123334455;
    localparam logic [47:0] SC   = 48'h0C0000000007;
    localparam logic [47:0] SD   = 48'h0C0000000008;
    localparam logic [47:0] SE   = 48'h0C0000000009;
    localparam logic [47:0] DU   = 48'h0E0000000009;
    localparam logic [47:0] ONES = 48'hFFFFFFFFFFFF;

    logic                     clk     = 1'b0;
    logic                     rstn    = 1'b0;
    logic                     psel    = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite  = 1'b0;
    logic [11:0]              paddr   = 12'h000;
    logic [31:0]              pwdata  = 32'h00000000;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     fvalid;
    mafa_pkg::mafa_frame_type frame;
    logic                     fwd_valid;
    logic                     fwd_pass;
    logic                     fwd_known;
    logic                     fwd_port;
    int                       bad_count = 0;
    int                       tests_run = 0;

    // 20 MHz system clock
    always #25 clk = ~clk;

    mafa_top #(.TICK_CYCLES(8)) dut_u (
        .REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME_VALID_I(fvalid), .FRAME_I(frame),
        .FWD_VALID_O(fwd_valid), .FWD_PASS_O(fwd_pass), .FWD_KNOWN_O(fwd_known),
        .FWD_PORT_O(fwd_port)
    );

    mafa_frame_src src_u (.clk_i(clk), .frame_valid_o(fvalid), .frame_o(frame));

    task automatic final_report();
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No assumed latency; only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask

    // Filter entry written as four words: address low and high, mask low, then mask high with verdict and direction
    task automatic wfilt(input logic p, input logic [4:0] e, input logic [47:0] ad,
                         input logic [47:0] mk, input logic rej, input logic dst);
        wr({2'b01, p, e, 2'h0, 2'b00}, ad[31:0]);
        wr({2'b01, p, e, 2'h1, 2'b00}, {16'h0, ad[47:32]});
        wr({2'b01, p, e, 2'h2, 2'b00}, mk[31:0]);
        wr({2'b01, p, e, 2'h3, 2'b00}, {14'h0, dst, rej, mk[47:32]});
    endtask

    // One frame and its decision, looked at in the cycle it stands
    task automatic frm(input logic p, input logic [47:0] d, input logic [47:0] s,
                       input logic ep, input logic ek, input logic eo);
        src_u.send(p, d, s);
        #1;
        chk({31'h0, fwd_valid}, 32'h1);
        chk({31'h0, fwd_pass}, {31'h0, ep});
        chk({31'h0, fwd_known}, {31'h0, ek});
        chk({31'h0, fwd_port}, {31'h0, eo});
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(50 * 4000);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdc(mafa_pkg::CTRL_OFS, 32'h0, 1'b0);
        rdc(mafa_pkg::LIFE_OFS, 32'h14, 1'b0);
        rdc(mafa_pkg::LRN_OFS, 32'h0, 1'b0);
        rdc(12'h00C, 32'h0, 1'b1);
        wr(mafa_pkg::LRN_OFS, 32'h0000FFFF);
        rdc(mafa_pkg::LRN_OFS, 32'h0, 1'b0);
        wr(mafa_pkg::LIFE_OFS, 32'h3);
        rdc(mafa_pkg::LIFE_OFS, 32'h6, 1'b0);
        wr(mafa_pkg::LIFE_OFS, 32'h32);
        rdc(mafa_pkg::LIFE_OFS, 32'h28, 1'b0);
        // Wired table: prefix reject, exact zero destination, exact accept behind
        wfilt(1'b0, 5'd0, SA & 48'hFFFFFF000000, 48'hFFFFFF000000, 1'b1, 1'b0);
        wfilt(1'b0, 5'd1, 48'h0, ONES, 1'b1, 1'b1);
        wfilt(1'b0, 5'd2, SA, ONES, 1'b0, 1'b0);
        wr(mafa_pkg::CTRL_OFS, 32'h1);
        frm(1'b0, DU, SA, 1'b0, 1'b0, 1'b1);
        frm(1'b0, DU, SB, 1'b1, 1'b0, 1'b1);
        frm(1'b0, 48'h0, SB, 1'b0, 1'b0, 1'b1);
        frm(1'b0, 48'h000000000100, SB, 1'b1, 1'b0, 1'b1);
        frm(1'b1, DU, SA, 1'b1, 1'b0, 1'b0);
        wfilt(1'b1, 5'd31, SC, ONES, 1'b1, 1'b0);
        wr(mafa_pkg::CTRL_OFS, 32'h3);
        frm(1'b1, DU, SC, 1'b0, 1'b0, 1'b0);
        frm(1'b0, DU, SC, 1'b1, 1'b0, 1'b1);
        wr(mafa_pkg::CTRL_OFS, 32'h0);
        frm(1'b0, DU, SA, 1'b1, 1'b0, 1'b1);
        wr(mafa_pkg::CTRL_OFS, 32'h1);
        // Removal zeroes address and mask only; the stale reject bit must not act
        wfilt(1'b0, 5'd0, 48'h0, 48'h0, 1'b1, 1'b0);
        frm(1'b0, DU, SA, 1'b1, 1'b0, 1'b1);
        // Learned table: port association follows the last ingress
        frm(1'b1, DU, SD, 1'b1, 1'b0, 1'b0);
        frm(1'b0, SD, SB, 1'b1, 1'b1, 1'b1);
        frm(1'b0, SC, SB, 1'b1, 1'b1, 1'b0);
        // Aging at 6 s of 8 cycles: entry gone 41 to 48 cycles after last sight
        wr(mafa_pkg::LIFE_OFS, 32'h6);
        frm(1'b0, DU, SE, 1'b1, 1'b0, 1'b1);
        repeat (30) @(posedge clk);
        frm(1'b0, DU, SE, 1'b1, 1'b0, 1'b1);
        repeat (30) @(posedge clk);
        frm(1'b1, SE, SB, 1'b1, 1'b1, 1'b0);
        repeat (50) @(posedge clk);
        frm(1'b1, SE, SB, 1'b1, 1'b0, 1'b0);
        // Second reset in mid-run empties the learned table
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdc(mafa_pkg::LRN_OFS, 32'h0, 1'b0);
        frm(1'b0, SD, SB, 1'b1, 1'b0, 1'b1);
        final_report();
    end
endmodule // mafa_top_tb
